// *** logic/btwd_pkg.sv ***
// constants for the basic interval timer and watchdog control block
package btwd_pkg;
    // ===========================================================
    // register map
    localparam logic [7:0] CTRL_ADDR      = 8'hd3;
    localparam logic [7:0] COUNT_ADDR     = 8'hfd;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [7:0] READ_ZERO      = 8'h00;
    // ===========================================================
    // control field layout
    localparam int         WDT_CODE_MSB   = 7;
    localparam int         WDT_CODE_LSB   = 4;
    localparam int         SEL_MSB        = 3;
    localparam int         SEL_LSB        = 2;
    localparam int         CNT_CLR_BIT    = 1;
    localparam int         DIV_CLR_BIT    = 0;
    localparam logic [3:0] WDT_DISABLE    = 4'ha;
    localparam logic [1:0] SEL_DIV4096    = 2'h0;
    localparam logic [1:0] SEL_DIV1024    = 2'h1;
    localparam logic [1:0] SEL_DIV128     = 2'h2;
    localparam logic [1:0] SEL_INVALID    = 2'h3;
    // ===========================================================
    // divider
    localparam int         DIV_WIDTH      = 12;
    localparam logic [11:0] DIV_ONES      = 12'h0fff;
    localparam logic [11:0] MASK_4096     = 12'h0fff;
    localparam logic [11:0] MASK_1024     = 12'h03ff;
    localparam logic [11:0] MASK_128      = 12'h007f;
    localparam logic [11:0] DIV_ZERO      = 12'h0000;
    localparam logic [7:0] COUNT_ONE      = 8'h01;
    localparam logic [7:0] COUNT_MAX      = 8'hff;
endpackage : btwd_pkg

// *** logic/btwd_tick_if.sv ***
// carrier between the control top and the shared oscillator divider
`timescale 1ns/10ps
`default_nettype none
interface btwd_tick_if;
    logic        div_clear;
    logic        tick_4096;
    logic        tick_1024;
    logic        tick_128;

    modport ctrl (output div_clear, input tick_4096, input tick_1024, input tick_128);
    modport div  (input div_clear, output tick_4096, output tick_1024, output tick_128);
endinterface : btwd_tick_if
`default_nettype wire

// *** logic/btwd_divider.sv ***
// shared oscillator divider feeding the basic timer; timer 0 only gets the clear pulse on T0_DIV_CLEAR
`timescale 1ns/10ps
`default_nettype none
module btwd_divider (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RESET_N,
    // divider side of the carrier
    btwd_tick_if.div  tick
);
    logic [11:0] div_reg;

    function automatic logic tap(input logic [11:0] value, input logic [11:0] mask);
        tap = ((value & mask) == mask);
    endfunction : tap

    // ===========================================================
    // free running count, cleared on request
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_reg <= btwd_pkg::DIV_ZERO;
        end else if (tick.div_clear) begin
            div_reg <= btwd_pkg::DIV_ZERO;
        end else begin
            div_reg <= div_reg + 12'h0001;
        end
    end

    // ticks are one-cycle enables, never derived clocks
    assign tick.tick_4096 = tap(div_reg, btwd_pkg::MASK_4096);
    assign tick.tick_1024 = tap(div_reg, btwd_pkg::MASK_1024);
    assign tick.tick_128  = tap(div_reg, btwd_pkg::MASK_128);
endmodule : btwd_divider
`default_nettype wire

// *** logic/btwd_ctrl.sv ***
// basic interval timer and watchdog control top
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module btwd_ctrl (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    // register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // timer and watchdog status
    output logic      [7:0] BT_COUNT,
    output logic            WDT_ENABLE,
    output logic            WDT_RESET_REQ,
    output logic            T0_DIV_CLEAR
);
    // ===========================================================
    // declarations
    btwd_tick_if tick ();

    logic [7:0] ctrl_reg;
    logic [7:0] count_reg;
    logic [7:0] rdata_reg;
    logic       cnt_clr_reg;
    logic       div_clr_reg;
    logic       wdt_req_reg;
    logic       wr_ctrl;
    logic       sel_tick;
    logic       wdt_on;

    btwd_divider u_divider (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .tick    (tick.div)
    );

    // ===========================================================
    // decode
    assign wr_ctrl = WR && (ADDR == btwd_pkg::CTRL_ADDR);
    assign wdt_on  = (ctrl_reg[btwd_pkg::WDT_CODE_MSB:btwd_pkg::WDT_CODE_LSB]
                      != btwd_pkg::WDT_DISABLE);

    always_comb begin
        case (ctrl_reg[btwd_pkg::SEL_MSB:btwd_pkg::SEL_LSB])
            btwd_pkg::SEL_DIV4096: sel_tick = tick.tick_4096;
            btwd_pkg::SEL_DIV1024: sel_tick = tick.tick_1024;
            btwd_pkg::SEL_DIV128:  sel_tick = tick.tick_128;
            // invalid code: counter holds rather than guessing a rate
            default:               sel_tick = 1'b0;
        endcase
    end

    // ===========================================================
    // control register; clear bits are never stored
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_reg <= btwd_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= {WDATA[btwd_pkg::WDT_CODE_MSB:btwd_pkg::SEL_LSB], 2'h0};
        end
    end

    // one-cycle clear pulses, self-ending
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_clr_reg <= 1'b0;
            div_clr_reg <= 1'b0;
        end else begin
            cnt_clr_reg <= wr_ctrl && WDATA[btwd_pkg::CNT_CLR_BIT];
            div_clr_reg <= wr_ctrl && WDATA[btwd_pkg::DIV_CLR_BIT];
        end
    end

    assign tick.div_clear = div_clr_reg;

    // ===========================================================
    // basic timer counter and watchdog overflow
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            count_reg <= btwd_pkg::COUNT_RESET;
        end else if (cnt_clr_reg) begin
            count_reg <= btwd_pkg::COUNT_RESET;
        end else if (sel_tick && !div_clr_reg) begin
            count_reg <= count_reg + btwd_pkg::COUNT_ONE;
        end
    end

    // overflow only resets the chip while the watchdog is on
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wdt_req_reg <= 1'b0;
        end else begin
            wdt_req_reg <= wdt_on && sel_tick && !div_clr_reg && !cnt_clr_reg
                           && (count_reg == btwd_pkg::COUNT_MAX);
        end
    end

    // ===========================================================
    // read port, data in the cycle after the strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_reg <= btwd_pkg::READ_ZERO;
        end else if (RD) begin
            case (ADDR)
                btwd_pkg::CTRL_ADDR:  rdata_reg <= ctrl_reg;
                btwd_pkg::COUNT_ADDR: rdata_reg <= count_reg;
                default:              rdata_reg <= btwd_pkg::READ_ZERO;
            endcase
        end else begin
            rdata_reg <= btwd_pkg::READ_ZERO;
        end
    end

    // ===========================================================
    // outputs, all from flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            WDT_ENABLE <= 1'b1;
        end else begin
            WDT_ENABLE <= wdt_on;
        end
    end

    assign RDATA         = rdata_reg;
    assign BT_COUNT      = count_reg;
    assign WDT_RESET_REQ = wdt_req_reg;
    assign T0_DIV_CLEAR  = div_clr_reg;
endmodule : btwd_ctrl
`default_nettype wire

// *** sim/btwd_ctrl_monitor.sv ***
// port-level assertions for the timer and watchdog control block
`timescale 1ns/10ps
`default_nettype none
module btwd_ctrl_monitor (
    // clock and reset
    input wire logic       CLK,
    input wire logic       RESET_N,
    // register port and status
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] BT_COUNT,
    input wire logic       WDT_ENABLE,
    input wire logic       WDT_RESET_REQ,
    input wire logic       T0_DIV_CLEAR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // ============================================================
    // control register steps
    sequence ctl_wr;
        WR && ADDR == 8'hd3;
    endsequence
    sequence ctl_rd;
        RD && ADDR == 8'hd3;
    endsequence
    wdt_off_a: assert property (ctl_wr ##0 WDATA[7:4] == 4'ha |=> ##1 !WDT_ENABLE)
        else $error("watchdog still on");
    wdt_on_a: assert property (ctl_wr ##0 WDATA[7:4] != 4'ha |=> ##1 WDT_ENABLE)
        else $error("watchdog off");
    cnt_clear_a: assert property (ctl_wr ##0 WDATA[1] |=> ##1 BT_COUNT == 8'h00)
        else $error("counter not cleared");
    div_pulse_a: assert property (ctl_wr ##0 WDATA[0] |=> T0_DIV_CLEAR)
        else $error("no divider clear");
    div_quiet_a: assert property (ctl_wr ##0 !WDATA[0] |=> !T0_DIV_CLEAR)
        else $error("stray divider clear");
    clr_read_a: assert property (ctl_wr ##3 ctl_rd |=> RDATA == ($past(WDATA, 4) & 8'hfc))
        else $error("bad control readback");
    // counter moves only by one step or by a clear
    cnt_step_a: assert property ($changed(BT_COUNT) |->
        BT_COUNT == $past(BT_COUNT) + 8'h01 || BT_COUNT == 8'h00)
        else $error("counter jumped");
    // request is launched from the same control state that enable is registered from in the same cycle
    req_gated_a: assert property (WDT_RESET_REQ |-> WDT_ENABLE)
        else $error("watchdog request while off");
    req_pulse_a: assert property (WDT_RESET_REQ |=> !WDT_RESET_REQ)
        else $error("watchdog request too long");
    rd_idle_a: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data without strobe");
endmodule : btwd_ctrl_monitor
`default_nettype wire

// *** sim/test_btwd_ctrl.sv ***
// self-checking bench for the timer and watchdog control block
`timescale 1ns/10ps
`default_nettype none
module test_btwd_ctrl;
    logic       clk, reset_n, wr, rd, seen, wdt_enable, wdt_reset_req, t0_div_clear;
    logic [7:0] addr, wdata, rdata, bt_count, d, a;
    int         failures, checks_done, cycles, seed;
    btwd_ctrl uut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .BT_COUNT(bt_count), .WDT_ENABLE(wdt_enable),
        .WDT_RESET_REQ(wdt_reset_req), .T0_DIV_CLEAR(t0_div_clear));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ============================================================
    // helpers
    function automatic int period(input logic [1:0] s);
        return (s == 2'h0) ? 4096 : (s == 2'h1) ? 1024 : 128;
    endfunction : period
    function automatic int ticks(input logic [1:0] s);
        return (s == 2'h0) ? 2 : (s == 2'h1) ? 3 : 5;
    endfunction : ticks
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic wctl(input logic [7:0] v);
        @(posedge clk);
        addr <= 8'hd3;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1 chk("div clear", {7'h00, v[0]}, {7'h00, t0_div_clear});
        @(posedge clk);
        #1 if (v[1]) chk("count clear", 8'h00, bt_count);
    endtask : wctl
    task automatic rd_chk(input logic [7:0] ra, input logic [7:0] exp);
        @(posedge clk);
        addr <= ra;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("read", exp, rdata);
    endtask : rd_chk
    // full wrap at the fastest rate takes 256 x 128 cycles
    task automatic wdog_wait;
        seen = 1'b0;
        repeat (33100) begin
            @(posedge clk);
            #1 if (wdt_reset_req === 1'b1) seen = 1'b1;
        end
    endtask : wdog_wait
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            failures++;
            report_and_stop;
        end
    end
    // ============================================================
    // main sequence
    initial begin
        {wr, rd, addr, wdata, failures, checks_done, cycles} = '0;
        seed = 32'ha63a_ef33;
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1 chk("wdt after reset", 8'h01, {7'h00, wdt_enable});
        rd_chk(8'hd3, 8'h00);
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 8'ha3 : (i == 1) ? 8'hff : 8'($random(seed));
            wctl(d);
            rd_chk(8'hd3, d & 8'hfc);
            chk("wdt", {7'h00, d[7:4] != 4'ha}, {7'h00, wdt_enable});
            a = 8'($random(seed));
            if (a == 8'hd3 || a == 8'hfd) a = 8'h00;
            rd_chk(a, 8'h00);
        end
        $display("done register tests");
        // sample mid-interval so a cycle of write latency cannot matter
        for (int j = 0; j < 3; j++) begin
            wctl({4'h0, j[1:0], 2'b11});
            repeat (period(j[1:0]) * ticks(j[1:0]) + period(j[1:0]) / 2) @(posedge clk);
            #1 chk("count rate", 8'(ticks(j[1:0])), bt_count);
        end
        wctl(8'h0f);
        repeat (600) @(posedge clk);
        #1 chk("count held", 8'h00, bt_count);
        $display("done rate tests");
        wctl(8'h0b);
        wdog_wait;
        chk("wdt reset", 8'h01, {7'h00, seen});
        chk("wrap count", 8'h02, bt_count);
        wctl(8'hab);
        wdog_wait;
        chk("wdt quiet", 8'h00, {7'h00, seen});
        chk("wrap count", 8'h02, bt_count);
        $display("done watchdog tests");
        report_and_stop;
    end
endmodule : test_btwd_ctrl
bind btwd_ctrl btwd_ctrl_monitor mon (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .BT_COUNT(BT_COUNT),
    .WDT_ENABLE(WDT_ENABLE), .WDT_RESET_REQ(WDT_RESET_REQ), .T0_DIV_CLEAR(T0_DIV_CLEAR));
`default_nettype wire
